// ### common/icc_pkg.sv
package icc_pkg;
    localparam int COUNT_W = 16;

    typedef logic [2:0] icc_mode_t;
    localparam icc_mode_t MODE_TERMINAL  = 3'h0;
    localparam icc_mode_t MODE_ONE_SHOT  = 3'h1;
    localparam icc_mode_t MODE_RATE      = 3'h2;
    localparam icc_mode_t MODE_SQUARE    = 3'h3;
    localparam icc_mode_t MODE_SW_STROBE = 3'h4;
    localparam icc_mode_t MODE_HW_STROBE = 3'h5;

    // Idle: control word only; armed: count held, not loaded; run: counting
    typedef enum logic [1:0] {
        ICC_IDLE  = 2'h0,
        ICC_ARMED = 2'h1,
        ICC_RUN   = 2'h3
    } icc_state_t;

    typedef logic [1:0] icc_step_t;
    localparam icc_step_t STEP_ONE = 2'h1;
    localparam icc_step_t STEP_TWO = 2'h2;

    localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_TWO  = 16'h0002;
    localparam logic [COUNT_W-1:0] RESET_COUNT = 16'h0000;
    localparam logic               RESET_OUT   = 1'b1;
    localparam logic [3:0]         BCD_NINE    = 4'h9;
endpackage

// ### common/icc_step_if.sv
`timescale 1ns/1ps
interface icc_step_if;
    import icc_pkg::*;
    logic [COUNT_W-1:0] value;
    logic               bcd;
    icc_step_t          amount;
    logic [COUNT_W-1:0] result;

    modport client (output value, output bcd, output amount, input result);
    modport server (input value, input bcd, input amount, output result);
endinterface

// ### design/icc_step.sv
`timescale 1ns/1ps
module icc_step #(
    parameter int WIDTH = icc_pkg::COUNT_W
) (
    icc_step_if.server step
);
    import icc_pkg::*;

    localparam int DIGITS = WIDTH / 4;

    generate
        if (WIDTH % 4 != 0 || WIDTH != COUNT_W)
        begin : g_bad_width
            $error("icc_step: width must equal the counter width, a multiple of 4");
        end
    endgenerate

    // Digit-wise subtract with borrow; a digit below zero wraps by adding ten
    function automatic logic [WIDTH-1:0] bcd_sub(input logic [WIDTH-1:0] v,
                                                  input icc_step_t amt);
        logic [WIDTH-1:0] r;
        logic [4:0]       d;
        logic [3:0]       borrow;
        r      = v;
        borrow = {2'h0, amt};
        for (int i = 0; i < DIGITS; i++)
        begin
            d = {1'b0, v[i*4 +: 4]} - {1'b0, borrow};
            if (d[4])
            begin
                r[i*4 +: 4] = 4'(d[3:0] + BCD_NINE + 4'h1);
                borrow      = 4'h1;
            end
            else
            begin
                r[i*4 +: 4] = d[3:0];
                borrow      = 4'h0;
            end
        end
        return r;
    endfunction

    // Both forms wrap through zero to all nines or all ones
    wire [WIDTH-1:0] bin_result = step.value - WIDTH'(step.amount);
    wire [WIDTH-1:0] dec_result = bcd_sub(step.value, step.amount);

    assign step.result = step.bcd ? dec_result : bin_result;
endmodule // icc_step

// ### design/icc_counter.sv
// Summary of operation
// - Control word write resets control logic and sets output level at once.
// - Gate level is sampled on the counter clock rising edge; gate edges are caught on any clock.
// - Modes 0, 2, 3, 4: sampled gate level enables or suspends decrementing.
// - Modes 1, 2, 3, 5: gate rising edge sets latch, sampled and cleared.
// - Modes 2 and 3: gate low stops counting and forces output high immediately.
// - Loading and decrementing happen on the counter clock falling edge.
// - Initial count zero acts as the largest count, 65536 or 10000.
// - Modes 0, 1, 4, 5 wrap past zero to all ones or 9999.
// - Modes 2 and 3 reload the stored initial count on expiry; an odd mode 3 low half starts one lower.
`timescale 1ns/1ps
module icc_counter
    import icc_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic                 ctrl_write,
    input  wire icc_pkg::icc_mode_t   ctrl_mode,
    input  wire logic                 ctrl_bcd,
    input  wire logic                 count_write,
    input  wire logic [icc_pkg::COUNT_W-1:0] count_value,
    input  wire logic                 cnt_clk,
    input  wire logic                 gate,
    output logic                      out,
    output logic [icc_pkg::COUNT_W-1:0] count_now
);
    import icc_pkg::*;

    icc_mode_t          mode;
    logic               bcd;
    icc_state_t         state;
    logic [COUNT_W-1:0] init_count;
    logic [COUNT_W-1:0] count;
    logic               out_q;
    logic               fired;
    logic               load_pend;
    logic               cclk_prev;
    logic               gate_prev;
    logic               gate_lvl;
    logic               trig_latch;
    logic               trig_seen;

    icc_step_if step ();
    icc_step u_step (
        .step (step)
    );

    function automatic icc_mode_t fold_mode(input icc_mode_t m);
        // Codes 6 and 7 alias the periodic modes
        return (m[2] && m[1]) ? {1'b0, m[1:0]} : m;
    endfunction

    function automatic logic initial_level(input icc_mode_t m);
        return fold_mode(m) != MODE_TERMINAL;
    endfunction

    wire cclk_rise = cnt_clk && !cclk_prev;
    wire cclk_fall = !cnt_clk && cclk_prev;
    wire gate_rise = gate && !gate_prev;

    wire periodic   = (mode == MODE_RATE) || (mode == MODE_SQUARE);
    wire level_mode = (mode == MODE_TERMINAL) || periodic || (mode == MODE_SW_STROBE);
    wire edge_mode  = (mode == MODE_ONE_SHOT) || periodic || (mode == MODE_HW_STROBE);
    wire soft_load  = !edge_mode || periodic;

    // Gate low in periodic modes acts without waiting for any clock
    wire gate_block = periodic && !gate;
    wire run_enable = !level_mode || (gate_lvl && !gate_block);

    wire trig_hit   = edge_mode && trig_seen && (state != ICC_IDLE);
    wire start_load = load_pend && soft_load;
    wire do_load    = cclk_fall && (start_load || trig_hit);
    wire do_step    = cclk_fall && !do_load && (state == ICC_RUN) && run_enable;

    // Square wave: an odd count first drops by one, then by two
    assign step.value  = count;
    assign step.bcd    = bcd;
    assign step.amount = (mode == MODE_SQUARE && !count[0]) ? STEP_TWO :
                         (mode == MODE_SQUARE && out_q)     ? STEP_ONE :
                         (mode == MODE_SQUARE)              ? STEP_TWO : STEP_ONE;

    wire [COUNT_W-1:0] stepped   = step.result;
    wire               hit_zero  = (stepped == COUNT_ZERO);
    wire               rate_end  = (mode == MODE_RATE) && (count == COUNT_ONE);
    wire               rate_low  = (mode == MODE_RATE) && (count == COUNT_TWO);
    wire               sq_end    = (mode == MODE_SQUARE) && hit_zero;
    // Low half of an odd square wave starts one lower to take away three
    wire [COUNT_W-1:0] sq_reload = (out_q && init_count[0])
                                   ? {init_count[COUNT_W-1:1], 1'b0} : init_count;

    wire [COUNT_W-1:0] next_count =
        do_load                  ? init_count :
        !do_step                 ? count      :
        rate_end                 ? init_count :
        sq_end                   ? sq_reload  :
                                   stepped;

    logic next_out;
    always_comb
    begin
        next_out = out_q;
        if (gate_block)
            next_out = 1'b1;
        else if (do_load && mode == MODE_ONE_SHOT)
            next_out = 1'b0;
        else if (do_load)
            next_out = (mode != MODE_TERMINAL);
        else if (do_step)
        begin
            case (mode)
                MODE_TERMINAL:  next_out = out_q || hit_zero;
                MODE_ONE_SHOT:  next_out = out_q || hit_zero;
                MODE_RATE:      next_out = rate_end || !rate_low;
                MODE_SQUARE:    next_out = sq_end ? !out_q : out_q;
                MODE_SW_STROBE: next_out = !(hit_zero && !fired);
                MODE_HW_STROBE: next_out = !(hit_zero && !fired);
                default:        next_out = out_q;
            endcase
        end
    end

    // Write strobe overrides the held level without a clock edge
    assign out = ctrl_write ? initial_level(ctrl_mode) : (out_q || gate_block);

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cclk_prev <= 1'b0;
            // Starts high so a gate already high at release is no trigger
            gate_prev <= 1'b1;
            gate_lvl  <= 1'b0;
        end
        else
        begin
            cclk_prev <= cnt_clk;
            gate_prev <= gate;
            if (cclk_rise)
                gate_lvl <= gate;
        end
    end

    // Trigger latch: a new edge wins over the clear of an old one
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_latch <= 1'b0;
            trig_seen  <= 1'b0;
        end
        else if (ctrl_write)
        begin
            trig_latch <= 1'b0;
            trig_seen  <= 1'b0;
        end
        else
        begin
            trig_latch <= (edge_mode && gate_rise) || (trig_latch && !cclk_rise);
            if (cclk_rise)
                trig_seen <= trig_latch;
            else if (do_load)
                trig_seen <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode       <= MODE_TERMINAL;
            bcd        <= 1'b0;
            state      <= ICC_IDLE;
            init_count <= RESET_COUNT;
            load_pend  <= 1'b0;
        end
        else if (ctrl_write)
        begin
            mode      <= fold_mode(ctrl_mode);
            bcd       <= ctrl_bcd;
            state     <= ICC_IDLE;
            load_pend <= 1'b0;
        end
        else
        begin
            if (count_write)
                init_count <= count_value;
            // Running periodic counts keep their sequence until expiry
            load_pend <= (count_write && !(periodic && state == ICC_RUN))
                         || (load_pend && !do_load);
            if (do_load)
                state <= ICC_RUN;
            else if (count_write && state == ICC_IDLE)
                state <= ICC_ARMED;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count     <= RESET_COUNT;
            count_now <= RESET_COUNT;
            out_q     <= RESET_OUT;
            fired     <= 1'b0;
        end
        else if (ctrl_write)
        begin
            out_q <= initial_level(ctrl_mode);
            fired <= 1'b0;
        end
        else
        begin
            count     <= next_count;
            count_now <= next_count;
            out_q     <= next_out;
            fired     <= do_load ? 1'b0 : (fired || (do_step && hit_zero));
        end
    end
endmodule // icc_counter

// ### sim/icc_counter_assertions.sv
`timescale 1ns/1ps
module icc_counter_assertions
    import icc_pkg::*;
(
    input wire logic                          clock,
    input wire logic                          reset_n,
    input wire logic                          ctrl_write,
    input wire icc_pkg::icc_mode_t            ctrl_mode,
    input wire logic                          ctrl_bcd,
    input wire logic                          count_write,
    input wire logic [icc_pkg::COUNT_W-1:0]   count_value,
    input wire logic                          cnt_clk,
    input wire logic                          gate,
    input wire logic                          out,
    input wire logic [icc_pkg::COUNT_W-1:0]   count_now
);
    icc_mode_t          mode_q;
    logic               bcd_q;
    logic [COUNT_W-1:0] init_q;
    logic [4:0]         cw_age;
    wire                m23   = mode_q[1];
    wire                m2    = mode_q[1] && !mode_q[0];
    wire                m04   = (mode_q == MODE_TERMINAL) || (mode_q == MODE_SW_STROBE);
    // Loads after a write land within a few counter clocks; skip that window
    wire                quiet = cw_age >= 5'h14;
    wire [4:0]          next_cw_age = (ctrl_write || count_write) ? 5'h00
                                    : cw_age + {4'h0, cw_age != 5'h1f};

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= MODE_TERMINAL;
            bcd_q  <= 1'b0;
            init_q <= COUNT_ZERO;
            cw_age <= 5'h00;
        end
        else
        begin
            mode_q <= ctrl_write ? ctrl_mode : mode_q;
            bcd_q  <= ctrl_write ? ctrl_bcd : bcd_q;
            init_q <= count_write ? count_value : init_q;
            cw_age <= next_cw_age;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    AST_OUT_ON_CTRL:
    assert property (ctrl_write |-> out == (ctrl_mode != MODE_TERMINAL))
        else $error("out level wrong during control write");
    AST_IDLE_AFTER_CTRL:
    assert property (ctrl_write ##1 (!count_write) [*4] |-> $stable(count_now))
        else $error("count moved without a count after control write");
    AST_STEP_ON_FALL:
    assert property ($changed(count_now) |-> cw_age < 5'h03
        || ($past(cnt_clk, 2) && !$past(cnt_clk)) || ($past(cnt_clk, 3) && !$past(cnt_clk, 2)))
        else $error("count changed without a counter clock fall");
    AST_GATE_LOW_OUT:
    assert property (m23 && !gate && !ctrl_write |-> out)
        else $error("out not high while gate low");
    AST_GATE_LOW_HOLD:
    assert property (m23 && quiet && !gate && !$past(gate) && !$past(gate, 2) |=> $stable(count_now))
        else $error("count moved while gate low");
    AST_WRAP:
    assert property (m04 && quiet && $past(count_now) == COUNT_ZERO && $changed(count_now)
        |-> count_now == (bcd_q ? 16'h9999 : 16'hffff))
        else $error("wrong wrap value");
    AST_BCD_DIGITS:
    assert property (bcd_q && quiet |-> count_now[15:12] <= BCD_NINE && count_now[11:8] <= BCD_NINE
        && count_now[7:4] <= BCD_NINE && count_now[3:0] <= BCD_NINE)
        else $error("invalid decimal digit");
    AST_RELOAD:
    assert property (m2 && !bcd_q && quiet && $changed(count_now) |-> count_now == init_q
        || ($past(count_now) != COUNT_ONE && count_now == $past(count_now) - COUNT_ONE))
        else $error("rate mode step or reload wrong");
endmodule // icc_counter_assertions

bind icc_counter icc_counter_assertions chk (.clock(clock), .reset_n(reset_n),
    .ctrl_write(ctrl_write), .ctrl_mode(ctrl_mode), .ctrl_bcd(ctrl_bcd),
    .count_write(count_write), .count_value(count_value), .cnt_clk(cnt_clk),
    .gate(gate), .out(out), .count_now(count_now));

// ### sim/icc_host.sv
`timescale 1ns/1ps
module icc_host
    import icc_pkg::*;
(
    input  wire logic                        clock,
    output logic                             ctrl_write,
    output icc_pkg::icc_mode_t               ctrl_mode,
    output logic                             ctrl_bcd,
    output logic                             count_write,
    output logic [icc_pkg::COUNT_W-1:0]      count_value
);
    import icc_pkg::*;
    initial {ctrl_write, ctrl_mode, ctrl_bcd, count_write, count_value} = '0;

    // Entered at a falling edge; one-cycle strobes
    task automatic control(input icc_mode_t m, input logic b);
        ctrl_mode = m;
        ctrl_bcd = b;
        ctrl_write = 1'b1;
        @(negedge clock);
        ctrl_write = 1'b0;
        ctrl_mode = ~m;
    endtask

    // Callers keep counts at or above the mode minimum
    task automatic load(input logic [COUNT_W-1:0] v);
        count_value = v;
        count_write = 1'b1;
        @(negedge clock);
        count_write = 1'b0;
        count_value = ~v;
    endtask
endmodule // icc_host

// ### sim/interval_counter_common_ops_test.sv
`timescale 1ns/1ps
module interval_counter_common_ops_test;
    import icc_pkg::*;
    logic               clock   = 1'b0;
    logic               reset_n = 1'b0;
    logic               cnt_clk = 1'b0;
    logic               gate    = 1'b1;
    logic               ctrl_write, ctrl_bcd, count_write, out;
    icc_mode_t          ctrl_mode;
    logic [COUNT_W-1:0] count_value, count_now;
    int                 errors  = 0;
    int                 checks  = 0;

    always #2 clock = ~clock;

    icc_host host (.clock(clock), .ctrl_write(ctrl_write), .ctrl_mode(ctrl_mode),
        .ctrl_bcd(ctrl_bcd), .count_write(count_write), .count_value(count_value));
    icc_counter dut (.clock(clock), .reset_n(reset_n), .ctrl_write(ctrl_write),
        .ctrl_mode(ctrl_mode), .ctrl_bcd(ctrl_bcd), .count_write(count_write),
        .count_value(count_value), .cnt_clk(cnt_clk), .gate(gate), .out(out),
        .count_now(count_now));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One counter clock period; optionally drops gate after the rise
    task automatic tick(input logic drop_gate);
        cnt_clk = 1'b1;
        repeat (2) @(negedge clock);
        if (drop_gate)
            gate = 1'b0;
        repeat (2) @(negedge clock);
        cnt_clk = 1'b0;
        repeat (4) @(negedge clock);
    endtask

    task automatic run(input icc_mode_t m, input logic b, input logic [15:0] v,
                       input logic [15:0] e [4]);
        host.control(m, b);
        host.load(v);
        foreach (e[i])
        begin
            tick(1'b0);
            check("count_now", count_now, e[i]);
        end
    endtask

    task automatic t_wrap;
        run(MODE_TERMINAL, 1'b0, 16'h0002, '{16'h0002, 16'h0001, 16'h0000, 16'hffff});
        tick(1'b1);
        check("gate after rise", count_now, 16'hfffe);
        tick(1'b0);
        check("gate low", count_now, 16'hfffe);
        gate = 1'b1;
        $display("t_wrap done");
    endtask

    task automatic t_zero;
        run(MODE_TERMINAL, 1'b0, COUNT_ZERO, '{16'h0000, 16'hffff, 16'hfffe, 16'hfffd});
        run(MODE_SW_STROBE, 1'b1, COUNT_ZERO, '{16'h0000, 16'h9999, 16'h9998, 16'h9997});
        run(MODE_SW_STROBE, 1'b1, 16'h0100, '{16'h0100, 16'h0099, 16'h0098, 16'h0097});
        $display("t_zero done");
    endtask

    task automatic t_rate;
        run(MODE_RATE, 1'b0, 16'h0003, '{16'h0003, 16'h0002, 16'h0001, 16'h0003});
        tick(1'b0);
        tick(1'b0);
        check("out at one", {15'h0, out}, 16'h0000);
        gate = 1'b0;
        @(negedge clock);
        check("out gate low", {15'h0, out}, 16'h0001);
        tick(1'b0);
        check("count gate low", count_now, 16'h0001);
        gate = 1'b1;
        @(negedge clock);
        tick(1'b0);
        check("count trigger", count_now, 16'h0003);
        tick(1'b0);
        gate = 1'b0;
        tick(1'b0);
        check("count held at two", count_now, 16'h0002);
        gate = 1'b1;
        @(negedge clock);
        tick(1'b0);
        check("retrigger from two", count_now, 16'h0003);
        run(MODE_SQUARE, 1'b0, 16'h0004, '{16'h0004, 16'h0002, 16'h0004, 16'h0002});
        $display("t_rate done");
    endtask

    // Gate pulse ends before the next rise; the latch must hold it
    task automatic t_trig(input icc_mode_t m);
        gate = 1'b0;
        host.control(m, 1'b0);
        tick(1'b0);
        host.load(16'h0005);
        tick(1'b0);
        gate = 1'b1;
        @(negedge clock);
        gate = 1'b0;
        tick(1'b0);
        check("trigger load", count_now, 16'h0005);
        tick(1'b0);
        check("trigger step", count_now, 16'h0004);
        $display("t_trig done");
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        t_wrap;
        t_zero;
        t_rate;
        t_trig(MODE_ONE_SHOT);
        t_trig(MODE_HW_STROBE);
        final_report;
    end

    initial
    begin
        #100000;
        errors++;
        final_report;
    end
endmodule // interval_counter_common_ops_test
